// file: src/exsv_core.v
// Purpose: exception syndrome, vector offsets/prefix, machine-check status
// Assumes: register port is a single-cycle special register access port
// Notes:   bit numbering in comments is verilog order (31 = msb)
`timescale 1ns/1ps
`default_nettype none
`include "exsv_defines.vh"
module exsv_core (
    input  wire        mclk,
    input  wire        srst,
    // Special register access port
    input  wire        spr_wr,
    input  wire [9:0]  spr_addr,
    input  wire [31:0] spr_wdata,
    output reg  [31:0] spr_rdata,
    // Syndrome capture from pipeline
    input  wire        syn_load,
    input  wire [1:0]  lock_cause,
    input  wire        aux_unit_flag,
    input  wire        unimpl_op_flag,
    input  wire        byte_order_fault,
    input  wire        fp_enabled_exc,
    input  wire        fp_late_enable,
    input  wire        fp_cond_update_flag,
    input  wire        fp_compare_flag,
    input  wire [2:0]  cond_field_index,
    // Interrupt vectoring
    input  wire [3:0]  vec_sel,
    output reg  [31:0] vec_addr,
    // Machine check sources, one-cycle pulses
    input  wire [6:0]  mc_event,
    input  wire [31:0] machine_state,
    input  wire [31:0] return_pc,
    output wire        mc_take
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg  [31:0] syndrome_r;
    reg  [31:0] prefix_r;
    reg  [31:0] mc_raddr_r;
    reg  [31:0] mc_state_r;
    reg  [31:0] offset_mem [0:15];
    reg         mc_taken_r;
    wire [6:0]  type_q;
    wire        summary_q;
    wire        masked_q;
    wire [31:0] mc_status;
    reg  [31:0] syndrome_nxt;
    reg  [6:0]  type_set;
    integer     i;
    integer     j;

    wire check_en = machine_state[`EXSV_MSR_CHECK_EN];
    wire wr_status = spr_wr && (spr_addr == `EXSV_SPR_MC_STATUS);
    wire [31:0] clr_bits = wr_status ? (spr_wdata & `EXSV_MCS_WMASK) : 32'h00000000;

    // ----------------------------------------
    // Machine-check event priority
    // ----------------------------------------
    // One type bit per check even if sources coincide; lowest bit wins
    always @* begin
        type_set = 7'h00;
        for (i = 6; i >= 0; i = i - 1) begin
            if (mc_event[i]) begin
                type_set = 7'h00;
                type_set[i] = 1'b1;
            end
        end
    end
    wire any_check = |mc_event;

    // Status bits: 6:0 -> doc bits 7..1 reversed into place
    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : g_type
            exsv_sticky u_type (
                .mclk (mclk),
                .srst (srst),
                .set  (type_set[g]),
                .clr  (clr_bits[`EXSV_MCS_TYPE_HI - g]),
                .q_r  (type_q[g])
            );
        end
    endgenerate

    // Summary set together with the type bit
    exsv_sticky u_summary (
        .mclk (mclk),
        .srst (srst),
        .set  (any_check),
        .clr  (clr_bits[`EXSV_MCS_SUMMARY]),
        .q_r  (summary_q)
    );

    // Masked flag: check arrives while enable is off
    exsv_sticky u_masked (
        .mclk (mclk),
        .srst (srst),
        .set  (any_check && !check_en),
        .clr  (clr_bits[`EXSV_MCS_MASKED]),
        .q_r  (masked_q)
    );

    assign mc_status = {summary_q, type_q[0], type_q[1], type_q[2], type_q[3],
                        type_q[4], type_q[5], type_q[6], masked_q, 23'h000000};

    // Level request; pipeline takes it once, then we save state
    assign mc_take = summary_q && check_en;

    // ----------------------------------------
    // Syndrome formation
    // ----------------------------------------
    // Undefined fp detail bits are forced to zero, simplest safe choice
    always @* begin
        syndrome_nxt = `EXSV_RESET_ZERO;
        syndrome_nxt[`EXSV_SYN_LOCK_HI:`EXSV_SYN_LOCK_LO] =
            (lock_cause == 2'h3) ? `EXSV_LOCK_NONE : lock_cause;
        syndrome_nxt[`EXSV_SYN_AUX] = aux_unit_flag;
        syndrome_nxt[`EXSV_SYN_UNIMPL] = unimpl_op_flag;
        syndrome_nxt[`EXSV_SYN_BYTE_ORDER] = byte_order_fault;
        syndrome_nxt[`EXSV_SYN_IMPRECISE] = fp_enabled_exc && fp_late_enable;
        if (fp_enabled_exc && !fp_late_enable) begin
            syndrome_nxt[`EXSV_SYN_COND_UPDATE] = fp_cond_update_flag;
            syndrome_nxt[`EXSV_SYN_COMPARE] = fp_compare_flag;
            if (fp_cond_update_flag) begin
                syndrome_nxt[`EXSV_SYN_CFIELD_HI:`EXSV_SYN_CFIELD_LO] = cond_field_index;
            end
        end
    end

    // Capture wins over a software write in the same cycle
    always @(posedge mclk) begin
        if (srst) begin
            syndrome_r <= `EXSV_RESET_ZERO;
        end else if (syn_load) begin
            syndrome_r <= syndrome_nxt;
        end else if (spr_wr && spr_addr == `EXSV_SPR_SYNDROME) begin
            syndrome_r <= spr_wdata;
        end
    end

    // ----------------------------------------
    // Prefix, offsets, machine-check save registers
    // ----------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            prefix_r   <= `EXSV_RESET_ZERO;
            mc_raddr_r <= `EXSV_RESET_ZERO;
            mc_state_r <= `EXSV_RESET_ZERO;
            mc_taken_r <= 1'b0;
            // Own loop index, the priority loop owns i
            for (j = 0; j < 16; j = j + 1) begin
                offset_mem[j] <= `EXSV_RESET_ZERO;
            end
        end else begin
            mc_taken_r <= mc_take;
            if (spr_wr && spr_addr == `EXSV_SPR_PREFIX) begin
                prefix_r <= spr_wdata & `EXSV_PREFIX_MASK;
            end
            if (spr_wr && spr_addr[9:4] == `EXSV_SPR_OFFSET_PAGE) begin
                offset_mem[spr_addr[3:0]] <= spr_wdata & `EXSV_OFFSET_MASK;
            end
            // Save on the rising edge of the take request only
            if (mc_take && !mc_taken_r) begin
                mc_raddr_r <= return_pc & `EXSV_RADDR_MASK;
                mc_state_r <= machine_state;
            end else begin
                if (spr_wr && spr_addr == `EXSV_SPR_MC_RADDR) begin
                    mc_raddr_r <= spr_wdata & `EXSV_RADDR_MASK;
                end
                if (spr_wr && spr_addr == `EXSV_SPR_MC_STATE) begin
                    mc_state_r <= spr_wdata;
                end
            end
        end
    end

    // ----------------------------------------
    // Vector address
    // ----------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            vec_addr <= `EXSV_RESET_ZERO;
        end else begin
            // Index equals interrupt number in the fixed order
            vec_addr <= (prefix_r & `EXSV_PREFIX_MASK) |
                        (offset_mem[vec_sel] & `EXSV_OFFSET_MASK);
        end
    end

    // ----------------------------------------
    // Read data, registered, unmapped reads zero
    // ----------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            spr_rdata <= `EXSV_RESET_ZERO;
        end else if (spr_addr[9:4] == `EXSV_SPR_OFFSET_PAGE) begin
            spr_rdata <= offset_mem[spr_addr[3:0]];
        end else begin
            case (spr_addr)
                `EXSV_SPR_PREFIX:    spr_rdata <= prefix_r;
                `EXSV_SPR_SYNDROME:  spr_rdata <= syndrome_r;
                `EXSV_SPR_MC_RADDR:  spr_rdata <= mc_raddr_r;
                `EXSV_SPR_MC_STATE:  spr_rdata <= mc_state_r;
                `EXSV_SPR_MC_STATUS: spr_rdata <= mc_status;
                default:             spr_rdata <= `EXSV_RESET_ZERO;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: src/exsv_defines.vh
// Purpose: constants for the exception syndrome and vector block
// Assumes: bit 0 is the most significant bit of a 32-bit register
// Notes:   verilog index = 31 - documented bit number
`ifndef EXSV_DEFINES_VH
`define EXSV_DEFINES_VH

// ----------------------------------------
// Register numbers (10-bit special register space)
// ----------------------------------------
`define EXSV_SPR_PREFIX       10'h03f
`define EXSV_SPR_SYNDROME     10'h03e
`define EXSV_SPR_OFFSET_BASE  10'h190
`define EXSV_SPR_OFFSET_PAGE  6'h19
`define EXSV_SPR_MC_RADDR     10'h23a
`define EXSV_SPR_MC_STATE     10'h23b
`define EXSV_SPR_MC_STATUS    10'h23c

// ----------------------------------------
// Syndrome fields (verilog bit positions)
// ----------------------------------------
`define EXSV_SYN_LOCK_HI      21
`define EXSV_SYN_LOCK_LO      20
`define EXSV_SYN_AUX          19
`define EXSV_SYN_UNIMPL       18
`define EXSV_SYN_BYTE_ORDER   17
`define EXSV_SYN_IMPRECISE    16
`define EXSV_SYN_COND_UPDATE  4
`define EXSV_SYN_COMPARE      3
`define EXSV_SYN_CFIELD_HI    2
`define EXSV_SYN_CFIELD_LO    0
`define EXSV_LOCK_NONE        2'h0
`define EXSV_LOCK_FLUSH       2'h1
`define EXSV_LOCK_INVAL       2'h2

// ----------------------------------------
// Machine-check status fields
// ----------------------------------------
`define EXSV_MCS_SUMMARY      31
`define EXSV_MCS_TYPE_HI      30
`define EXSV_MCS_TYPE_LO      24
`define EXSV_MCS_MASKED       23
`define EXSV_MCS_WMASK        32'hff800000

// ----------------------------------------
// Vector fields and machine state
// ----------------------------------------
`define EXSV_PREFIX_MASK      32'hffff0000
`define EXSV_OFFSET_MASK      32'h0000fff0
`define EXSV_RADDR_MASK       32'hfffffffc
`define EXSV_MSR_CHECK_EN     12
`define EXSV_VEC_MCHECK       4'h1
`define EXSV_RESET_ZERO       32'h00000000

`endif

// file: src/exsv_sticky.v
// Purpose: one sticky status bit, set wins over clear
// Assumes: synchronous active-high reset
// Notes:   used for each machine-check status bit
`timescale 1ns/1ps
`default_nettype none
module exsv_sticky (
    input  wire mclk,
    input  wire srst,
    input  wire set,
    input  wire clr,
    output reg  q_r
);
    // ----------------------------------------
    // Sticky bit
    // ----------------------------------------
    // Set beats clear so an event in the clearing cycle is kept
    always @(posedge mclk) begin
        if (srst) begin
            q_r <= 1'b0;
        end else if (set) begin
            q_r <= 1'b1;
        end else if (clr) begin
            q_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: test/exsv_core_chk.sv
// Purpose: port assertions for exsv_core
// Assumes: one clock, sync reset
// Notes:   reads land one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module exsv_core_chk (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic [9:0]  spr_addr,
    input wire logic [31:0] spr_rdata,
    input wire logic        syn_load,
    input wire logic [1:0]  lock_cause,
    input wire logic        aux_unit_flag,
    input wire logic        unimpl_op_flag,
    input wire logic        byte_order_fault,
    input wire logic        fp_enabled_exc,
    input wire logic        fp_late_enable,
    input wire logic        fp_cond_update_flag,
    input wire logic        fp_compare_flag,
    input wire logic [2:0]  cond_field_index,
    input wire logic [6:0]  mc_event,
    input wire logic [31:0] machine_state,
    input wire logic        mc_take
);
    // ----------
    // Checks
    // ----------
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Syndrome seen through a read right after capture
    a_lock_field: assert property (syn_load ##1 spr_addr == 10'h03e |=> spr_rdata[21:20] ==
        ($past(lock_cause, 2) == 2'h3 ? 2'h0 : $past(lock_cause, 2))) else $error("lock field");
    a_syn_flags: assert property (syn_load ##1 spr_addr == 10'h03e |=> spr_rdata[19:17] ==
        {$past(aux_unit_flag, 2), $past(unimpl_op_flag, 2), $past(byte_order_fault, 2)}) else $error("flags");
    a_imprecise_bit: assert property (syn_load ##1 spr_addr == 10'h03e |=> spr_rdata[16] ==
        ($past(fp_enabled_exc, 2) && $past(fp_late_enable, 2))) else $error("imprecise");
    a_fp_detail: assert property (syn_load && fp_enabled_exc && !fp_late_enable && fp_cond_update_flag ##1
        spr_addr == 10'h03e |=> spr_rdata[4:0] == {1'b1, $past(fp_compare_flag, 2), $past(cond_field_index, 2)})
        else $error("fp detail");
    // Machine check: summary, type, masked flag, saved state
    a_take_follow: assert property (|mc_event && machine_state[12] ##1 machine_state[12] |-> mc_take)
        else $error("take missing");
    a_take_enable: assert property (mc_take |-> machine_state[12]) else $error("take while off");
    a_flush_type: assert property (mc_event == 7'h40 ##1 spr_addr == 10'h23c |=> spr_rdata[31:24] == 8'h81)
        else $error("flush type");
    a_masked_flag: assert property (|mc_event && !machine_state[12] ##1 spr_addr == 10'h23c |=> spr_rdata[23])
        else $error("masked flag");
    a_saved_state: assert property ($rose(mc_take) ##1 spr_addr == 10'h23b |=> spr_rdata == $past(machine_state, 2))
        else $error("saved state");
endmodule
bind exsv_core exsv_core_chk u_chk (.mclk, .srst, .spr_addr, .spr_rdata, .syn_load, .lock_cause, .aux_unit_flag,
    .unimpl_op_flag, .byte_order_fault, .fp_enabled_exc, .fp_late_enable, .fp_cond_update_flag,
    .fp_compare_flag, .cond_field_index, .mc_event, .machine_state, .mc_take);
`default_nettype wire

// file: test/exsv_src_model.sv
// Purpose: model of the bus and parity event sources
// Assumes: pulses launched on the falling edge
// Notes:   always back to quiet after a pulse
`timescale 1ns/1ps
`default_nettype none
module exsv_src_model (
    input  wire logic       mclk,
    output var  logic [6:0] mc_event
);
    // Quiet from time zero, no stray event
    initial mc_event = 7'h00;
    // One-cycle pulse, as the sources give
    task automatic fire(input logic [6:0] bits);
        @(negedge mclk) mc_event = bits;
        @(negedge mclk) mc_event = 7'h00;
    endtask
endmodule
`default_nettype wire

// file: test/tb_exception_syndrome_and_vectors.sv
// Purpose: self-checking bench for exsv_core
// Assumes: inputs change on the falling edge
// Notes:   syndrome cases in a table, the rest by hand
`timescale 1ns/1ps
`default_nettype none
module tb_exception_syndrome_and_vectors;
    logic        mclk, srst, spr_wr, syn_load, mc_take;
    logic [9:0]  spr_addr;
    logic [31:0] spr_wdata, spr_rdata, vec_addr, machine_state, return_pc;
    logic [11:0] fld;
    logic [3:0]  vec_sel;
    logic [6:0]  mc_event;
    int          num_errors = 0, total_checks = 0, cyc = 0;
    // Capture fields beside the syndrome they should give
    logic [43:0] rows [0:9] = '{44'h400_00100000, 44'h800_00200000, 44'hc00_00000000, 44'h200_00080000,
        44'h100_00040000, 44'h080_00020000, 44'h05d_0000001d, 44'h052_00000012, 44'h060_00010000,
        44'h020_00000000};
    exsv_core DUT (.mclk, .srst, .spr_wr, .spr_addr, .spr_wdata, .spr_rdata, .syn_load,
        .lock_cause(fld[11:10]), .aux_unit_flag(fld[9]), .unimpl_op_flag(fld[8]), .byte_order_fault(fld[7]),
        .fp_enabled_exc(fld[6]), .fp_late_enable(fld[5]), .fp_cond_update_flag(fld[4]),
        .fp_compare_flag(fld[3]), .cond_field_index(fld[2:0]), .vec_sel, .vec_addr, .mc_event,
        .machine_state, .return_pc, .mc_take);
    exsv_src_model PM (.mclk, .mc_event);
    // ----------
    // Clock, watchdog and tasks
    // ----------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Cut a hang well past the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(negedge mclk) {spr_wr, spr_addr, spr_wdata} = {1'b1, a, d};
        @(negedge mclk) spr_wr = 1'b0;
    endtask
    // Read data is registered, so look one cycle later
    task automatic rc(input logic [9:0] a, input logic [31:0] e);
        @(negedge mclk) spr_addr = a;
        @(negedge mclk) chk(spr_rdata, e);
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------
    // Main sequence
    // ----------
    initial begin
        {srst, spr_wr, syn_load, spr_addr, spr_wdata, fld, vec_sel} = {3'b100, 58'h0};
        machine_state = 32'h0000_1000;
        return_pc = 32'h8000_0007;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        rc(10'h23c, 32'h0);
        rc(10'h3ff, 32'h0);
        $display("test reset and unmapped done");
        for (int i = 0; i < 10; i++) begin
            @(negedge mclk) {fld, syn_load} = {rows[i][43:32], 1'b1};
            @(negedge mclk) {syn_load, spr_addr} = {1'b0, 10'h03e};
            @(negedge mclk) chk(spr_rdata, rows[i][31:0]);
        end
        // Capture and software write on one edge: capture wins
        @(negedge mclk) {fld, syn_load, spr_wr, spr_wdata} = {12'h200, 2'b11, 32'hffff_ffff};
        @(negedge mclk) {syn_load, spr_wr} = 2'b00;
        @(negedge mclk) chk(spr_rdata, 32'h0008_0000);
        $display("test syndrome done");
        wr(10'h03f, 32'h1234_abcd);
        rc(10'h03f, 32'h1234_0000);
        for (int i = 0; i < 16; i++) wr(10'h190 + i[9:0], {16'hffff, i[3:0], 12'h5a7});
        for (int i = 0; i < 16; i++) begin
            @(negedge mclk) vec_sel = i[3:0];
            @(negedge mclk) chk(vec_addr, {16'h1234, i[3:0], 8'h5a, 4'h0});
        end
        $display("test vectors done");
        PM.fire(7'h02);
        rc(10'h23b, 32'h0000_1000);
        rc(10'h23a, 32'h8000_0004);
        rc(10'h23c, 32'ha000_0000);
        chk({31'h0, mc_take}, 32'h1);
        wr(10'h23c, 32'ha000_0000);
        rc(10'h23c, 32'h0);
        chk({31'h0, mc_take}, 32'h0);
        PM.fire(7'h60);
        rc(10'h23c, 32'h8200_0000);
        wr(10'h23c, 32'hff80_0000);
        machine_state = 32'h0;
        for (int k = 0; k < 7; k++) begin
            PM.fire(7'h01 << k);
            rc(10'h23c, 32'h8080_0000 | (32'h4000_0000 >> k));
            chk({31'h0, mc_take}, 32'h0);
            wr(10'h23c, 32'hff80_0000);
        end
        $display("test machine check done");
        @(negedge mclk) srst = 1'b1;
        @(negedge mclk) srst = 1'b0;
        rc(10'h03f, 32'h0);
        $display("test second reset done");
        finish_test();
    end
endmodule
`default_nettype wire
